// ### sim/sam_alarm_mgr_properties.sv
`timescale 1ns/1ps
module sam_chk #(
  parameter int HOLD_UNIT = 4
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [1:0] warn_cause_e6,
  input wire logic warn_cause_e7,
  input wire logic warn_cause_e9,
  input wire logic power_clear,
  input wire logic err_reset,
  input wire logic fault_out_first_axis,
  input wire logic fault_out_second_axis,
  input wire logic [1:0] dyn_brake,
  input wire logic [1:0] axis_halt,
  input wire logic [1:0] warn_other_axis,
  input wire logic [11:0] disp_code,
  input wire logic disp_is_alarm
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  property p_warn; (|warn_cause_e6 || warn_cause_e7 || warn_cause_e9) |=> axis_halt == 2'h3;
  endproperty
  property p_brk_a; !fault_out_first_axis |-> dyn_brake[0]; endproperty
  property p_brk_b; !fault_out_second_axis |-> dyn_brake[1]; endproperty
  property p_disp; $fell(fault_out_first_axis) || $fell(fault_out_second_axis) |-> disp_is_alarm;
  endproperty
  property p_stop; disp_is_alarm && disp_code inside {12'h010, 12'h047, 12'h888} |-> axis_halt == 2'h3;
  endproperty
  property p_other; |warn_other_axis |-> axis_halt == 2'h3; endproperty
  property p_err; !fault_out_first_axis && disp_code == 12'h052 && err_reset |-> ##2 fault_out_first_axis;
  endproperty
  // A power clear needs two edges to reach the display, so two quiet samples are required.
  property p_wdog; (!power_clear)[*2] ##0 (disp_is_alarm && disp_code == 12'h888) |=> disp_is_alarm;
  endproperty
  a_warn: assert property (p_warn) else $error("warning stop");
  a_brk_a: assert property (p_brk_a) else $error("brake a");
  a_brk_b: assert property (p_brk_b) else $error("brake b");
  a_disp: assert property (p_disp) else $error("alarm display");
  a_stop: assert property (p_stop) else $error("stop all");
  a_other: assert property (p_other) else $error("other axis stop");
  a_err: assert property (p_err) else $error("error reset");
  a_wdog: assert property (p_wdog) else $error("power only");
  c_err: cover property (err_reset && !fault_out_first_axis);
  c_wdog: cover property (disp_code == 12'h888);
  c_other: cover property (|warn_other_axis);
endmodule : sam_chk

// ### sim/sam_alarm_mgr_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fail_count++; \
  $display("[FAIL] %0t %h %h", $time, (a), (b)); end end
module sam_alarm_mgr_tb;
  logic sys_clk = 1'b0, rst_n = 1'b0, go = 1'b0, warn_cause_e7 = 1'b0, warn_cause_e9 = 1'b0;
  logic power_clear, err_reset, cpu_reset, busy, disp_is_alarm;
  logic fault_out_first_axis, fault_out_second_axis;
  logic [1:0] alarm_req = 2'h0, warn_cause_e6 = 2'h0, load_level_sel = 2'h0;
  logic [1:0] dyn_brake, axis_halt, warn_other_axis;
  logic [3:0] alarm_detail = 4'h0, disp_detail;
  logic [7:0] load_level_a = 8'h03, load_level_b = 8'h03, wait_cyc = 8'h00;
  logic [11:0] alarm_code = 12'h000, disp_code;
  logic [11:0] th [5] = '{12'h030, 12'h045, 12'h046, 12'h050, 12'h051};
  logic [11:0] wc [3] = '{12'h0e6, 12'h0e7, 12'h0e9};
  sam_pkg::sam_clr_t kind = sam_pkg::SAM_CLR_ERR;
  int fail_count = 0, tests_run = 0, cyc = 0;
  sam_alarm_mgr #(.HOLD_UNIT(4)) i_dut (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .alarm_req(alarm_req),
    .alarm_code(alarm_code),
    .alarm_detail(alarm_detail),
    .warn_cause_e6(warn_cause_e6),
    .warn_cause_e7(warn_cause_e7),
    .warn_cause_e9(warn_cause_e9),
    .load_level_sel(load_level_sel),
    .load_level_a(load_level_a),
    .load_level_b(load_level_b),
    .power_clear(power_clear),
    .err_reset(err_reset),
    .cpu_reset(cpu_reset),
    .fault_out_first_axis(fault_out_first_axis),
    .fault_out_second_axis(fault_out_second_axis),
    .dyn_brake(dyn_brake),
    .axis_halt(axis_halt),
    .warn_other_axis(warn_other_axis),
    .disp_code(disp_code),
    .disp_detail(disp_detail),
    .disp_is_alarm(disp_is_alarm)
  );
  sam_ctrl_model i_ctrl (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .go(go),
    .kind(kind),
    .wait_cyc(wait_cyc),
    .power_clear(power_clear),
    .err_reset(err_reset),
    .cpu_reset(cpu_reset),
    .busy(busy)
  );
  always #50 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      close_out();
    end
  end
  task automatic close_out();
    if (fail_count == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : close_out
  task automatic raise(input logic [1:0] r, input logic [11:0] c, input logic [3:0] d);
    @(posedge sys_clk);
    alarm_req <= r;
    alarm_code <= c;
    alarm_detail <= d;
    @(posedge sys_clk);
    alarm_req <= 2'h0;
    @(posedge sys_clk);
    #1;
  endtask : raise
  task automatic clr(input sam_pkg::sam_clr_t k, input logic [7:0] w);
    @(posedge sys_clk);
    kind <= k;
    wait_cyc <= w;
    go <= 1'b1;
    @(posedge sys_clk);
    go <= 1'b0;
    #1;
    for (int i = 0; i < 300 && busy === 1'b1; i++) begin
      @(posedge sys_clk);
      #1;
    end
    @(posedge sys_clk);
    #1;
  endtask : clr
  task automatic t_axis();
    for (int x = 0; x < 2; x++) begin
      raise(x ? 2'h2 : 2'h1, 12'h052, 4'h0);
      `CHK({fault_out_first_axis, fault_out_second_axis}, x ? 2'h2 : 2'h1)
      `CHK(dyn_brake, x ? 2'h2 : 2'h1)
      `CHK(disp_code, 12'h052)
      clr(sam_pkg::SAM_CLR_ERR, 8'h00);
      `CHK({fault_out_first_axis, fault_out_second_axis}, 2'h3)
    end
  endtask : t_axis
  task automatic t_common();
    for (int d = 1; d < 3; d++) begin
      raise(2'h2, 12'h010, d[3:0]);
      `CHK(axis_halt, 2'h3)
      `CHK(disp_detail, d[3:0])
      `CHK(fault_out_first_axis, 1'b0)
      `CHK(warn_other_axis, 2'h2)
      clr(sam_pkg::SAM_CLR_CPU, 8'h00);
      `CHK(fault_out_first_axis, 1'b1)
    end
  endtask : t_common
  task automatic t_power();
    for (int i = 0; i < 2; i++) begin
      raise(2'h1, i ? 12'h888 : 12'h047, 4'h0);
      clr(sam_pkg::SAM_CLR_ERR, 8'h00);
      `CHK(fault_out_first_axis, 1'b0)
      clr(sam_pkg::SAM_CLR_CPU, 8'h00);
      `CHK(disp_is_alarm, 1'b1)
      clr(sam_pkg::SAM_CLR_POWER, 8'h00);
      `CHK(fault_out_first_axis, 1'b1)
    end
  endtask : t_power
  // Load 3 gives a hold of 16 cycles, so an early clear must fail and a late one succeed.
  task automatic t_thermal();
    foreach (th[i]) begin
      raise(2'h1, th[i], 4'h0);
      clr(sam_pkg::SAM_CLR_ERR, 8'h00);
      `CHK(fault_out_first_axis, 1'b0)
      clr(sam_pkg::SAM_CLR_ERR, 8'h28);
      `CHK(fault_out_first_axis, 1'b1)
    end
  endtask : t_thermal
  task automatic t_warn();
    for (int i = 0; i < 3; i++) begin
      @(posedge sys_clk);
      warn_cause_e6 <= {1'b0, i == 0};
      warn_cause_e7 <= i == 1;
      warn_cause_e9 <= i == 2;
      repeat (3) @(posedge sys_clk);
      #1;
      `CHK(axis_halt, 2'h3)
      `CHK(disp_code, wc[i])
      @(posedge sys_clk);
      {warn_cause_e6, warn_cause_e7, warn_cause_e9} <= 4'h0;
      repeat (3) @(posedge sys_clk);
      #1;
      `CHK(axis_halt, 2'h0)
    end
  endtask : t_warn
  initial begin
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_axis();
    t_common();
    t_power();
    t_thermal();
    t_warn();
    close_out();
  end
endmodule : sam_alarm_mgr_tb
bind sam_alarm_mgr sam_chk #(.HOLD_UNIT(HOLD_UNIT)) i_chk (
  .sys_clk(sys_clk),
  .rst_n(rst_n),
  .warn_cause_e6(warn_cause_e6),
  .warn_cause_e7(warn_cause_e7),
  .warn_cause_e9(warn_cause_e9),
  .power_clear(power_clear),
  .err_reset(err_reset),
  .fault_out_first_axis(fault_out_first_axis),
  .fault_out_second_axis(fault_out_second_axis),
  .dyn_brake(dyn_brake),
  .axis_halt(axis_halt),
  .warn_other_axis(warn_other_axis),
  .disp_code(disp_code),
  .disp_is_alarm(disp_is_alarm)
);

// ### sim/sam_ctrl_model.sv
`timescale 1ns/1ps
module sam_ctrl_model (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic go,
  input wire sam_pkg::sam_clr_t kind,
  input wire logic [7:0] wait_cyc,
  output logic power_clear,
  output logic err_reset,
  output logic cpu_reset,
  output logic busy
);
  logic [7:0] cnt;
  // No position-lost code exists in this block, so no home setting is ever owed.
  // One request per go, held a single cycle so the device sees exactly one clear event.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      {power_clear, err_reset, cpu_reset, busy, cnt} <= 12'h000;
    end else if (go && !busy) begin
      busy <= 1'b1;
      cnt <= wait_cyc;
    end else if (cnt != 8'h00) begin
      cnt <= cnt - 8'h01;
    end else if (busy && !(power_clear | err_reset | cpu_reset)) begin
      power_clear <= kind == sam_pkg::SAM_CLR_POWER;
      err_reset <= kind == sam_pkg::SAM_CLR_ERR;
      cpu_reset <= kind == sam_pkg::SAM_CLR_CPU;
    end else begin
      {power_clear, err_reset, cpu_reset, busy} <= 4'h0;
    end
  end
endmodule : sam_ctrl_model

// ### src/sam_alarm_mgr.sv
`timescale 1ns/1ps
`include "sam_defines.svh"
module sam_alarm_mgr #(
  parameter int HOLD_UNIT = `SAM_HOLD_MIN_CYC
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [1:0] alarm_req,
  input wire logic [`SAM_CODE_W-1:0] alarm_code,
  input wire logic [3:0] alarm_detail,
  input wire logic [1:0] warn_cause_e6,
  input wire logic warn_cause_e7,
  input wire logic warn_cause_e9,
  input wire logic [1:0] load_level_sel,
  input wire logic [`SAM_LOAD_W-1:0] load_level_a,
  input wire logic [`SAM_LOAD_W-1:0] load_level_b,
  input wire logic power_clear,
  input wire logic err_reset,
  input wire logic cpu_reset,
  output logic fault_out_first_axis,
  output logic fault_out_second_axis,
  output logic [1:0] dyn_brake,
  output logic [1:0] axis_halt,
  output logic [1:0] warn_other_axis,
  output logic [`SAM_CODE_W-1:0] disp_code,
  output logic [3:0] disp_detail,
  output logic disp_is_alarm
);
  // Classify a code into detection and stop scope and permitted clearing.
  function automatic sam_pkg::sam_attr_t sam_classify(input logic [`SAM_CODE_W-1:0] c);
    sam_pkg::sam_attr_t a;
    a = '{common: 1'b0, stop_all: 1'b0, any_clear: 1'b0, thermal: 1'b0};
    unique case (c)
      `SAM_A_UV: a = '{1'b1, 1'b1, 1'b1, 1'b0};
      `SAM_A_RGN, `SAM_A_HEAT: a = '{1'b1, 1'b1, 1'b1, 1'b1};
      `SAM_A_DDHEAT, `SAM_A_OL1, `SAM_A_OL2: a = '{1'b0, 1'b0, 1'b1, 1'b1};
      `SAM_A_ERREX: a = '{1'b0, 1'b0, 1'b1, 1'b0};
      `SAM_A_USBTO, `SAM_A_USBER: a = '{1'b1, 1'b1, 1'b1, 1'b0};
      `SAM_A_FAN, `SAM_A_WDOG: a = '{1'b1, 1'b1, 1'b0, 1'b0};
      default: a = '{1'b0, 1'b0, 1'b0, 1'b0};
    endcase
    return a;
  endfunction : sam_classify

  sam_pkg::sam_attr_t attr;
  logic [1:0] req_eff;
  logic [1:0] act;
  logic [1:0] stop_req;
  logic [`SAM_CODE_W-1:0] lat_a;
  logic [`SAM_CODE_W-1:0] lat_b;
  logic [`SAM_CODE_W-1:0] lat [2];
  logic ctrl_clear;
  logic [3:0] detail;
  logic [3:0] next_detail;
  logic [1:0] next_halt;
  logic [1:0] next_warn_ob;
  logic [1:0] next_fault;
  logic [`SAM_CODE_W-1:0] next_disp_code;
  logic [3:0] next_disp_detail;
  logic next_disp_is_alarm;
  logic any_stop_all;
  logic common_warn;

  always_comb begin
    attr = sam_classify(alarm_code);
    // A common code lands on the first axis slot only, so it is raised once.
    req_eff = attr.common ? {1'b0, |alarm_req} : alarm_req;
    ctrl_clear = err_reset || cpu_reset;
  end

  for (genvar g = 0; g < 2; g++) begin : g_axis
    sam_axis #(.HOLD_UNIT(HOLD_UNIT)) u_axis (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .alarm_req(req_eff[g]),
      .alarm_code(alarm_code),
      .alarm_attr(attr),
      .load_level(g == 0 ? load_level_a : load_level_b),
      .power_clear(power_clear),
      .ctrl_clear(ctrl_clear),
      .alarm_active(act[g]),
      .alarm_latched(lat[g]),
      .stop_all(stop_req[g])
    );
  end
  assign lat_a = lat[0];
  assign lat_b = lat[1];

  always_comb begin
    common_warn = warn_cause_e7 || warn_cause_e9 || (|warn_cause_e6);
    any_stop_all = (|(act & stop_req)) || common_warn;
    // Only an all-axes alarm reports to the partner; a per-axis alarm leaves it running.
    next_warn_ob = {act[0] & stop_req[0], act[1] & stop_req[1]};
    // A warning stop from E6, E7 or E9 brakes the axis but is no alarm, so the fault output stays high.
    next_fault = act | {2{|(act & stop_req)}};
    next_halt = act;
    if (any_stop_all || (|next_warn_ob)) begin
      next_halt = 2'b11;
    end
    next_detail = detail;
    if (alarm_code == `SAM_A_UV && (|alarm_req)) begin
      next_detail = alarm_detail;
    end
    next_disp_is_alarm = |act;
    if (act[0]) begin
      next_disp_code = lat_a;
    end else if (act[1]) begin
      next_disp_code = lat_b;
    end else if (warn_cause_e7) begin
      next_disp_code = `SAM_W_CFS;
    end else if (|warn_cause_e6) begin
      next_disp_code = `SAM_W_SFS;
    end else if (warn_cause_e9) begin
      next_disp_code = `SAM_W_MOFF;
    end else if (|next_warn_ob) begin
      next_disp_code = `SAM_W_OAX;
    end else begin
      next_disp_code = `SAM_NONE;
    end
    next_disp_detail = (next_disp_code == `SAM_A_UV) ? next_detail : 4'h0;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_out_first_axis <= 1'b0;
      fault_out_second_axis <= 1'b0;
      dyn_brake <= 2'b11;
      axis_halt <= 2'b00;
      warn_other_axis <= 2'b00;
      disp_code <= `SAM_NONE;
      disp_detail <= 4'h0;
      disp_is_alarm <= 1'b0;
      detail <= 4'h0;
    end else begin
      // Output high means healthy; an axis in alarm shows the fault, and every halted axis brakes, warning stops included.
      fault_out_first_axis <= !next_fault[0];
      fault_out_second_axis <= !next_fault[1];
      dyn_brake <= next_halt;
      axis_halt <= next_halt;
      warn_other_axis <= next_warn_ob;
      disp_code <= next_disp_code;
      disp_detail <= next_disp_detail;
      disp_is_alarm <= next_disp_is_alarm;
      detail <= next_detail;
    end
  end
endmodule : sam_alarm_mgr

// ### src/sam_axis.sv
`timescale 1ns/1ps
`include "sam_defines.svh"
module sam_axis #(
  parameter int HOLD_UNIT = `SAM_HOLD_MIN_CYC
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic alarm_req,
  input wire logic [`SAM_CODE_W-1:0] alarm_code,
  input wire sam_pkg::sam_attr_t alarm_attr,
  input wire logic [`SAM_LOAD_W-1:0] load_level,
  input wire logic power_clear,
  input wire logic ctrl_clear,
  output logic alarm_active,
  output logic [`SAM_CODE_W-1:0] alarm_latched,
  output logic stop_all
);
  sam_pkg::sam_state_t state;
  sam_pkg::sam_state_t next_state;
  logic [`SAM_CODE_W-1:0] next_alarm_latched;
  logic next_stop_all;
  logic [31:0] hold_cnt;
  logic [31:0] next_hold_cnt;
  logic thermal;
  logic any_clear;
  logic next_thermal;
  logic next_any_clear;

  // Hold grows with the load seen at the moment of the alarm.
  always_comb begin
    next_state = state;
    next_alarm_latched = alarm_latched;
    next_stop_all = stop_all;
    next_hold_cnt = (hold_cnt != 32'h0) ? hold_cnt - 32'h1 : hold_cnt;
    next_thermal = thermal;
    next_any_clear = any_clear;
    unique case (state)
      sam_pkg::SAM_ST_RUN: begin
        if (alarm_req) begin
          next_state = sam_pkg::SAM_ST_ALARM;
          next_alarm_latched = alarm_code;
          next_stop_all = alarm_attr.stop_all;
          next_thermal = alarm_attr.thermal;
          next_any_clear = alarm_attr.any_clear;
          next_hold_cnt = alarm_attr.thermal ?
            32'(HOLD_UNIT) * (32'(load_level) + 32'h1) : 32'h0;
        end
      end
      sam_pkg::SAM_ST_ALARM, sam_pkg::SAM_ST_COOL: begin
        if (power_clear ||
            (ctrl_clear && any_clear && (!thermal || hold_cnt == 32'h0))) begin
          next_state = sam_pkg::SAM_ST_RUN;
          next_alarm_latched = `SAM_NONE;
          next_stop_all = 1'b0;
        end else if (thermal && hold_cnt == 32'h0) begin
          next_state = sam_pkg::SAM_ST_COOL;
        end
      end
      default: next_state = sam_pkg::SAM_ST_RUN;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= sam_pkg::SAM_ST_RUN;
      alarm_latched <= `SAM_NONE;
      stop_all <= 1'b0;
      hold_cnt <= 32'h0;
      thermal <= 1'b0;
      any_clear <= 1'b0;
    end else begin
      state <= next_state;
      alarm_latched <= next_alarm_latched;
      stop_all <= next_stop_all;
      hold_cnt <= next_hold_cnt;
      thermal <= next_thermal;
      any_clear <= next_any_clear;
    end
  end

  assign alarm_active = (state != sam_pkg::SAM_ST_RUN);
endmodule : sam_axis

// ### src/sam_defines.svh
// Notes on behaviour
// - Per-axis codes raise on detecting axis only; common codes raise once for both.
// - Per-axis stop scope halts only the detecting axis; other axis keeps running.
// - All-axes stop scope halts both axes whatever axis detected it.
// - 8A, 8E, 52, thermal codes clear by any means; 47, 888 only power cycle.
// - Warnings E6, E7, E9 are common and stop all axes.
// - Warning EB is detected per axis but stops all axes.
// - Thermal alarms refuse controller clear until a load-derived hold time expires.
// - Any alarm drops the axis fault output and engages its dynamic brake.
// - An active alarm shows its number on the display; with both axes in alarm, the first axis's number is shown.
// - Undervoltage alarm 10 stops all axes; detail 1 control, 2 main supply.
// - Warnings cancel by themselves once their cause disappears.
`ifndef SAM_DEFINES_SVH
`define SAM_DEFINES_SVH
`define SAM_CODE_W 12
`define SAM_NONE 12'h000
`define SAM_A_UV 12'h010
`define SAM_A_RGN 12'h030
`define SAM_A_HEAT 12'h045
`define SAM_A_DDHEAT 12'h046
`define SAM_A_FAN 12'h047
`define SAM_A_OL1 12'h050
`define SAM_A_OL2 12'h051
`define SAM_A_ERREX 12'h052
`define SAM_A_USBTO 12'h08a
`define SAM_A_USBER 12'h08e
`define SAM_A_WDOG 12'h888
`define SAM_W_SFS 12'h0e6
`define SAM_W_CFS 12'h0e7
`define SAM_W_MOFF 12'h0e9
`define SAM_W_OAX 12'h0eb
`define SAM_DET_CTRL 4'h1
`define SAM_DET_MAIN 4'h2
`define SAM_CLK_HZ 10000000
`define SAM_HOLD_MIN_S 1
`define SAM_HOLD_MIN_CYC (`SAM_CLK_HZ * `SAM_HOLD_MIN_S)
`define SAM_LOAD_W 8
`endif

// ### src/sam_pkg.sv
package sam_pkg;
  typedef enum logic [1:0] {
    SAM_CLR_NONE,
    SAM_CLR_POWER,
    SAM_CLR_ERR,
    SAM_CLR_CPU
  } sam_clr_t;
  typedef enum logic [1:0] {
    SAM_ST_RUN,
    SAM_ST_ALARM,
    SAM_ST_COOL
  } sam_state_t;
  typedef struct packed {
    logic common;
    logic stop_all;
    logic any_clear;
    logic thermal;
  } sam_attr_t;
endpackage : sam_pkg
